//--- xdata_or_pkg.sv
// constants and types for the table-read / external-move / multiply / or executor
// assumes an 8-bit core with byte-wide program and external data memory interfaces
// Summary of operation
// RULE_01 - table read via data pointer: 93h, two cycles
// RULE_02 - pc-based table read: advance pc first
// RULE_03 - full sixteen-bit unsigned sum, flags untouched
// RULE_04 - index register form: eight-bit address on port zero
// RULE_05 - pointer form: high on port two, low port zero
// RULE_06 - port two latch untouched during external move
// RULE_07 - external read through index: E2h/E3h, two cycles
// RULE_08 - external write through index: F2h/F3h, two cycles
// RULE_09 - multiply: low to accumulator, high to b, four cycles
// RULE_10 - multiply sets overflow above 255, clears carry
// RULE_11 - no operation: one byte, one cycle, pc+1
// RULE_12 - byte or stores result, flags untouched
// RULE_13 - or on a port reads its latch
// RULE_14 - or working register: 48h-4Fh, one cycle
// RULE_15 - or direct into accumulator: 45h, one cycle
// RULE_16 - or immediate into accumulator: 44h, one cycle
// RULE_17 - or accumulator into direct: 42h, one cycle
// RULE_18 - or immediate into direct: 43h, two cycles
// RULE_19 - other forms follow the standard opcode map
package xdata_or_pkg;
  localparam logic [7:0] OP_TBL_DATA_POINTER = 8'h93;
  localparam logic [7:0] OP_TBL_PC = 8'h83;
  localparam logic [6:0] OP_XRD_RI = 7'h71;
  localparam logic [7:0] OP_XRD_DP = 8'hE0;
  localparam logic [6:0] OP_XWR_RI = 7'h79;
  localparam logic [7:0] OP_XWR_DP = 8'hF0;
  localparam logic [7:0] OP_MUL = 8'hA4;
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [4:0] OP_OR_RN = 5'h09;
  localparam logic [6:0] OP_OR_RI = 7'h23;
  localparam logic [7:0] OP_OR_DIR = 8'h45;
  localparam logic [7:0] OP_OR_IMM = 8'h44;
  localparam logic [7:0] OP_OR_DA = 8'h42;
  localparam logic [7:0] OP_OR_DI = 8'h43;
  localparam logic [7:0] PORT2_ADDR = 8'hA0;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_FOUR = 3'h4;
  typedef enum logic [2:0] {ST_FETCH, ST_OPER1, ST_OPER2, ST_EXEC} state_t;
endpackage : xdata_or_pkg

//--- code_xdata_mul_or_exec.sv
// executor for table read, external move, multiply, no operation and byte or
// assumes memories answer in the same cycle; internal ram and sfrs reached by direct port
`timescale 1ns/1ps
module code_xdata_mul_or_exec (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // program memory
  output logic [15:0] codeAddr,
  input wire logic [7:0] codeData,
  // internal data (registers, ram, sfr latches)
  output logic [7:0] iramAddr,
  input wire logic [7:0] iramRdata,
  output logic [7:0] iramWdata,
  output logic iramWe,
  // external data bus
  output logic [7:0] portZeroAddrData,
  output logic [7:0] portTwoHighAddr,
  output logic portTwoDrive,
  output logic xRead,
  output logic xWrite,
  input wire logic [7:0] xDataIn,
  // core state
  input wire logic [7:0] bankBase,
  input wire logic [15:0] dataPointer,
  output logic [7:0] acc,
  output logic [7:0] bReg,
  output logic carry,
  output logic overflowFlag,
  output logic [15:0] pc,
  output logic [2:0] cycleCount,
  output logic busy
);
  import xdata_or_pkg::*;

  state_t state;
  logic [7:0] opcode;
  logic [7:0] operand1;
  logic [2:0] cyc;
  logic [2:0] target;
  logic [7:0] xDataSync1;
  logic [7:0] xDataSync;
  logic [7:0] iramRdataHold;
  logic [7:0] target8;

  // opcode classes
  wire isTblDp = (opcode == OP_TBL_DATA_POINTER);
  wire isTblPc = (opcode == OP_TBL_PC);
  wire isXrdRi = (opcode[7:1] == OP_XRD_RI);
  wire isXwrRi = (opcode[7:1] == OP_XWR_RI);
  wire isXrdDp = (opcode == OP_XRD_DP);
  wire isXwrDp = (opcode == OP_XWR_DP);
  wire isMul = (opcode == OP_MUL);
  wire isNop = (opcode == OP_NOP);
  wire isOrRn = (opcode[7:3] == OP_OR_RN);
  wire isOrRi = (opcode[7:1] == OP_OR_RI);
  wire isOrDir = (opcode == OP_OR_DIR);
  wire isOrImm = (opcode == OP_OR_IMM);
  wire isOrDa = (opcode == OP_OR_DA);
  wire isOrDi = (opcode == OP_OR_DI);
  wire isXdp = isXrdDp | isXwrDp;
  wire isXri = isXrdRi | isXwrRi;
  wire needOper1 = isOrDir | isOrImm | isOrDa | isOrDi;
  wire needOper2 = isOrDi;

  // fetched opcode classes, decoded from codeData while fetching
  wire [7:0] fo = codeData;
  wire fNeed1 = (fo == OP_OR_DIR) | (fo == OP_OR_IMM) | (fo == OP_OR_DA) | (fo == OP_OR_DI);

  // cycle budget per instruction
  wire [2:0] cycBudget = isMul ? CYC_FOUR :                 // RULE_09
    (isTblDp | isTblPc | isXri | isXdp | isOrDi | isOrRi) ? CYC_TWO : // RULE_01 RULE_02 RULE_07 RULE_08 RULE_18 RULE_19
    CYC_ONE;                                                // RULE_11 RULE_14 RULE_15 RULE_16 RULE_17

  // table read address: pc already advanced past the one-byte opcode
  wire [15:0] accWide = {8'h00, acc};
  wire [15:0] tblBase = isTblPc ? pc : dataPointer;         // RULE_02
  wire [15:0] tblAddr = accWide + tblBase;                  // RULE_03

  // external addressing
  wire [7:0] riAddr = bankBase + {7'h00, opcode[0]};
  wire [2:0] rnSel = opcode[2:0];
  wire [15:0] mulProd = acc * bReg;                         // RULE_09
  wire mulOv = (mulProd > {8'h00, BYTE_MAX});               // RULE_10

  // internal address by phase
  wire inExec = (state == ST_EXEC);
  wire [7:0] rnAddr = bankBase + {5'h00, rnSel};
  // indirect or: first cycle reads the pointer, second reads what it points at
  wire [7:0] execIramAddr = isOrRn ? rnAddr :
    (isXri && cyc == CYC_ONE) ? riAddr :
    (isOrRi && cyc == CYC_ONE) ? iramRdata :
    isOrRi ? iramRdataHold :
    operand1;
  // register address decoded from the opcode byte while it is fetched
  wire [7:0] fetchRegAddr = bankBase + (fo[3] ? {5'h00, fo[2:0]} : {7'h00, fo[0]});

  // or result; direct reads of a port come from its latch through iramRdata (RULE_13)
  wire [7:0] orSrcAcc = (isOrImm) ? operand1 : iramRdata;
  wire [7:0] orAccRes = acc | orSrcAcc;                     // RULE_12
  wire [7:0] orDirRes = iramRdata | (isOrDi ? target8 : acc); // RULE_12 RULE_13

  wire lastCyc = inExec && (cyc == cycBudget);
  wire pcStep = (state == ST_FETCH) | (state == ST_OPER1) | (state == ST_OPER2);

  wire [7:0] next_acc =
    (isTblDp | isTblPc) ? codeData :                        // RULE_01 RULE_02
    (isXrdRi | isXrdDp) ? xDataSync :                       // RULE_07
    isMul ? mulProd[7:0] :                                  // RULE_09
    (isOrRn | isOrDir | isOrImm | isOrRi) ? orAccRes :      // RULE_14 RULE_15 RULE_16 RULE_19
    acc;

  // code address: fetch at pc, table read at sum
  // codeAddr is registered, so it must lead pc by the step taken this cycle
  wire [15:0] next_codeAddr = (inExec && (isTblDp | isTblPc) && !lastCyc) ? tblAddr :
    pcStep ? pc + 16'h0001 : pc;

  // external bus drive
  wire xPhase = inExec && (isXri | isXdp) && !lastCyc;
  wire [7:0] next_p0 = xPhase ? (isXdp ? dataPointer[7:0] : iramRdata) : // RULE_04 RULE_05
    (inExec && (isXwrRi | isXwrDp) && lastCyc) ? acc : BYTE_RESET;
  wire [7:0] next_p2 = dataPointer[15:8];                   // RULE_05

  always_ff @(posedge clk) begin
    if (reset) begin
      xDataSync1 <= BYTE_RESET;
      xDataSync <= BYTE_RESET;
    end else begin
      xDataSync1 <= xDataIn;
      xDataSync <= xDataSync1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ST_FETCH;
      opcode <= OP_NOP;
      operand1 <= BYTE_RESET;
      target8 <= BYTE_RESET;
      iramRdataHold <= BYTE_RESET;
      cyc <= CYC_ONE;
      pc <= PC_RESET;
      acc <= BYTE_RESET;
      bReg <= BYTE_RESET;
      carry <= 1'b0;
      overflowFlag <= 1'b0;
    end else begin
      unique case (state)
        ST_FETCH: begin
          opcode <= codeData;
          pc <= pc + 16'h0001;                              // RULE_02 RULE_11
          cyc <= CYC_ONE;
          state <= fNeed1 ? ST_OPER1 : ST_EXEC;
        end
        ST_OPER1: begin
          operand1 <= codeData;
          pc <= pc + 16'h0001;
          state <= needOper2 ? ST_OPER2 : ST_EXEC;
        end
        ST_OPER2: begin
          target8 <= codeData;                              // RULE_18
          pc <= pc + 16'h0001;
          state <= ST_EXEC;
        end
        ST_EXEC: begin
          iramRdataHold <= iramRdata;
          if (lastCyc) begin
            acc <= next_acc;
            if (isMul) begin
              bReg <= mulProd[15:8];                        // RULE_09
              overflowFlag <= mulOv;                        // RULE_10
              carry <= 1'b0;                                // RULE_10
            end
            state <= ST_FETCH;
          end else begin
            cyc <= cyc + CYC_ONE;
          end
        end
        default: state <= ST_FETCH;
      endcase
    end
  end

  // internal writes: only or-to-direct; never the port two latch on external moves (RULE_06)
  wire doDirWrite = lastCyc && (isOrDa | isOrDi);           // RULE_17 RULE_18
  // address is registered: present it one cycle ahead of the cycle that reads it
  wire [7:0] next_iramAddr = inExec ? execIramAddr :
    (state == ST_FETCH) ? fetchRegAddr :
    (state == ST_OPER1) ? codeData :
    operand1;

  always_ff @(posedge clk) begin
    if (reset) begin
      codeAddr <= PC_RESET;
      portZeroAddrData <= BYTE_RESET;
      portTwoHighAddr <= BYTE_RESET;
      portTwoDrive <= 1'b0;
      xRead <= 1'b0;
      xWrite <= 1'b0;
      iramAddr <= BYTE_RESET;
      iramWdata <= BYTE_RESET;
      iramWe <= 1'b0;
      cycleCount <= CYC_ONE;
      busy <= 1'b0;
    end else begin
      codeAddr <= next_codeAddr;
      portZeroAddrData <= next_p0;
      portTwoHighAddr <= next_p2;
      portTwoDrive <= xPhase && isXdp;                      // RULE_05 RULE_06
      xRead <= inExec && (isXrdRi | isXrdDp);
      xWrite <= inExec && (isXwrRi | isXwrDp) && lastCyc;   // RULE_08
      iramAddr <= next_iramAddr;
      iramWdata <= orDirRes;
      iramWe <= doDirWrite;
      cycleCount <= cycBudget;
      busy <= !(state == ST_FETCH) || pcStep;
    end
  end

  AST_MUL_CARRY: assert property (@(posedge clk) disable iff (reset)
    (inExec && isMul && lastCyc) |=> !carry) else $error("carry not cleared"); // RULE_10
  AST_MUL_OV: assert property (@(posedge clk) disable iff (reset)
    (inExec && isMul && lastCyc) |=> (overflowFlag == $past(mulOv))) else $error("bad overflow"); // RULE_10
  AST_MUL_B: assert property (@(posedge clk) disable iff (reset)
    (inExec && isMul && lastCyc) |=> (bReg == $past(mulProd[15:8]))) else $error("bad high byte"); // RULE_09
  AST_NOP_ACC: assert property (@(posedge clk) disable iff (reset)
    (inExec && isNop) |=> $stable(acc) && $stable(bReg)) else $error("nop changed state"); // RULE_11
  AST_TBL_SUM: assert property (@(posedge clk) disable iff (reset)
    (inExec && isTblDp && !lastCyc) |=> (codeAddr == $past(accWide + dataPointer))) else $error("bad table addr"); // RULE_03
  AST_OR_FLAGS: assert property (@(posedge clk) disable iff (reset)
    (inExec && (isOrRn | isOrImm) && lastCyc) |=> $stable(carry) && $stable(overflowFlag)) else $error("or touched flags"); // RULE_12
  AST_OR_IMM: assert property (@(posedge clk) disable iff (reset)
    (inExec && isOrImm) |=> (acc == ($past(acc) | $past(operand1)))) else $error("bad or result"); // RULE_16
  AST_MUL_LEN: assert property (@(posedge clk) disable iff (reset)
    (state == ST_FETCH && codeData == OP_MUL) |=> inExec [*4] ##1 (state == ST_FETCH)) else $error("multiply not four cycles"); // RULE_09
  AST_XWR_STROBE: assert property (@(posedge clk) disable iff (reset)
    (inExec && isXwrRi && lastCyc) |=> xWrite && (portZeroAddrData == $past(acc))) else $error("write data missing"); // RULE_08
endmodule : code_xdata_mul_or_exec

//--- xmem_model.sv
// program memory, internal ram with port latches, and external bus watcher
// assumes same-cycle answers as the executor expects
`timescale 1ns/1ps
module xmem_model (
  // clock
  input wire logic clk,
  // program memory
  input wire logic [15:0] codeAddr,
  output logic [7:0] codeData,
  // internal data
  input wire logic [7:0] iramAddr,
  output logic [7:0] iramRdata,
  input wire logic [7:0] iramWdata,
  input wire logic iramWe,
  // external bus
  input wire logic [7:0] portZeroAddrData,
  input wire logic [7:0] portTwoHighAddr,
  input wire logic portTwoDrive,
  input wire logic xWrite
);
  logic [7:0] code [0:255];
  logic [7:0] iram [0:255];
  logic [7:0] lastWrite;
  logic [7:0] highSeen;
  // table space above 0x100 is a pattern so carries land somewhere distinct
  assign codeData = (codeAddr < 16'h0100) ? code[codeAddr[7:0]] : (codeAddr[7:0] ^ codeAddr[15:8] ^ 8'h5A);
  // port addresses answer with the latch, not pins
  assign iramRdata = iram[iramAddr];
  always @(posedge clk) begin
    if (iramWe) iram[iramAddr] <= iramWdata;
    // data phase follows address phase, so last value wins
    if (xWrite) lastWrite <= portZeroAddrData;
    if (portTwoDrive) highSeen <= portTwoHighAddr;
  end
endmodule : xmem_model

//--- code_xdata_mul_or_exec_tb.sv
// self-checking bench: short programs per reset, results checked as pc passes 0x40
// assumes unused code bytes are zero and run as no operation
`timescale 1ns/1ps
module code_xdata_mul_or_exec_tb;
  import xdata_or_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] b; logic ov; logic [7:0] chk; logic [7:0] mem; logic [7:0] wr; logic [7:0] hi;} exp_t;
  logic clk = 1'b0, reset = 1'b1, iramWe, xWrite, portTwoDrive, ov, cy;
  logic [15:0] codeAddr, pc, dataPointer = 16'h0000, dp;
  logic [7:0] codeData, iramAddr, iramRdata, iramWdata, pZ, pT, acc, bReg;
  logic [7:0] bankBase = 8'h00, xDataIn = 8'h00, r1, r2, bb, xd;
  integer seed = 49;
  int n_mismatch = 0, samples_checked = 0;
  exp_t q[$];
  exp_t e, m;
  code_xdata_mul_or_exec code_xdata_mul_or_exec_i (.clk(clk), .reset(reset), .codeAddr(codeAddr),
    .codeData(codeData), .iramAddr(iramAddr), .iramRdata(iramRdata), .iramWdata(iramWdata), .iramWe(iramWe),
    .portZeroAddrData(pZ), .portTwoHighAddr(pT), .portTwoDrive(portTwoDrive), .xRead(), .xWrite(xWrite),
    .xDataIn(xDataIn), .bankBase(bankBase), .dataPointer(dataPointer), .acc(acc), .bReg(bReg), .carry(cy),
    .overflowFlag(ov), .pc(pc), .cycleCount(), .busy());
  xmem_model xmem_model_i (.clk(clk), .codeAddr(codeAddr), .codeData(codeData), .iramAddr(iramAddr),
    .iramRdata(iramRdata), .iramWdata(iramWdata), .iramWe(iramWe), .portZeroAddrData(pZ),
    .portTwoHighAddr(pT), .portTwoDrive(portTwoDrive), .xWrite(xWrite));
  initial forever #2 clk = ~clk;
  task automatic check(input string nm, input logic [7:0] ex, input logic [7:0] got);
    samples_checked++;
    if (got !== ex) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : check
  task automatic summarize();
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  function automatic logic [7:0] codeAt(input logic [15:0] a);
    return (a < 16'h0100) ? xmem_model_i.code[a[7:0]] : (a[7:0] ^ a[15:8] ^ 8'h5A);
  endfunction : codeAt
  task automatic start();
    @(posedge clk);
    reset <= 1'b1;
    r1 = $random(seed);
    r2 = $random(seed);
    bb = {3'h0, 2'($random(seed)), 3'h0};
    dp = $random(seed);
    xd = $random(seed);
    bankBase <= bb;
    dataPointer <= dp;
    xDataIn <= xd;
    @(posedge clk);
    for (int k = 0; k < 256; k++) begin
      xmem_model_i.code[k] = 8'h00;
      xmem_model_i.iram[k] = 8'h00;
    end
    xmem_model_i.highSeen = 8'h00;
    xmem_model_i.lastWrite = 8'h00;
    e = '0;
    e.chk = 8'h30;
  endtask : start
  task automatic prog(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    xmem_model_i.code[0] = b0;
    xmem_model_i.code[1] = b1;
    xmem_model_i.code[2] = b2;
  endtask : prog
  task automatic go();
    q.push_back(e);
    @(posedge clk);
    reset <= 1'b0;
    for (int k = 0; k < 300 && pc !== 16'h0041; k++) @(posedge clk);
  endtask : go
  always @(posedge clk) begin
    if (pc === 16'h0040 && q.size() > 0) begin
      m = q.pop_front();
      check("acc", m.a, acc);
      check("bReg", m.b, bReg);
      check("overflowFlag", {7'h00, m.ov}, {7'h00, ov});
      check("carry", 8'h00, {7'h00, cy});
      check("iram", m.mem, xmem_model_i.iram[m.chk]);
      check("xwrite", m.wr, xmem_model_i.lastWrite);
      check("highAddr", m.hi, xmem_model_i.highSeen);
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    for (int n = 0; n < 8; n++) begin
      start();
      prog(OP_OR_IMM, r1, {OP_OR_RN, 3'(n)});
      xmem_model_i.iram[bb + 8'(n)] = r2;
      e.a = r1 | r2;
      go();
    end
    start();
    prog(OP_OR_IMM, r1, OP_OR_DIR);
    xmem_model_i.code[3] = 8'h30;
    xmem_model_i.iram[8'h30] = r2;
    {e.a, e.mem} = {r1 | r2, r2};
    go();
    start();
    prog(OP_OR_IMM, r1, OP_OR_DA);
    xmem_model_i.code[3] = 8'h30;
    xmem_model_i.iram[8'h30] = r2;
    {e.a, e.mem} = {r1, r1 | r2};
    go();
    start();
    prog(OP_OR_DI, PORT2_ADDR, r1);
    xmem_model_i.iram[PORT2_ADDR] = r2;
    {e.chk, e.mem} = {PORT2_ADDR, r1 | r2};
    go();
    for (int t = 0; t < 2; t++) begin
      start();
      prog(OP_OR_IMM, r1, (t == 0) ? OP_TBL_DATA_POINTER : OP_TBL_PC);
      e.a = (t == 0) ? codeAt(dp + {8'h00, r1}) : codeAt(16'h0003 + {8'h00, r1});
      go();
    end
    for (int i = 0; i < 2; i++) begin
      start();
      prog({OP_XRD_RI, 1'(i)}, 8'h00, 8'h00);
      xmem_model_i.iram[bb + 8'(i)] = r2;
      e.a = xd;
      go();
      start();
      prog(OP_OR_IMM, r1, {OP_XWR_RI, 1'(i)});
      {e.a, e.wr} = {r1, r1};
      go();
    end
    start();
    prog(OP_OR_IMM, r1, OP_XWR_DP);
    xmem_model_i.iram[PORT2_ADDR] = r2;
    {e.a, e.wr, e.chk, e.mem, e.hi} = {r1, r1, PORT2_ADDR, r2, dp[15:8]};
    go();
    start();
    prog(OP_XRD_DP, OP_NOP, OP_NOP);
    {e.a, e.hi} = {xd, dp[15:8]};
    go();
    start();
    prog(OP_OR_IMM, r1, OP_MUL);
    go();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
endmodule : code_xdata_mul_or_exec_tb
